// ==== hdl/dac_chain_shifter.sv ====
`timescale 1ns/1ps
module dac_chain_shifter import dac_seq_pkg::*; (
	input wire logic clk,
	input wire logic nrst,
	input wire logic start,
	input wire logic [CHAIN_W-1:0] frame,
	output logic sclk,
	output logic sdo,
	output logic load_n,
	output logic done
);
	logic [CHAIN_W-1:0] sr_q, sr_d;
	logic [8:0] bits_q, bits_d;
	logic busy_q, busy_d, phase_q, phase_d;
	logic sclk_d, sdo_d, load_n_d, done_d;

	always_comb begin
		sr_d = sr_q;
		bits_d = bits_q;
		busy_d = busy_q;
		phase_d = phase_q;
		sclk_d = sclk;
		sdo_d = sdo;
		load_n_d = 1'b1;
		done_d = 1'b0;
		if (!busy_q) begin
			if (start) begin
				sr_d = frame;
				bits_d = 9'(CHAIN_W);
				busy_d = 1'b1;
				phase_d = 1'b0;
			end
		end else if (bits_q != 9'h000) begin
			if (!phase_q) begin
				sdo_d = sr_q[CHAIN_W-1];
				sclk_d = 1'b0;
				phase_d = 1'b1;
			end else begin
				sclk_d = 1'b1;
				sr_d = {sr_q[CHAIN_W-2:0], 1'b0};
				bits_d = bits_q - 9'h001;
				phase_d = 1'b0;
			end
		end else begin
			// every chip holds its word: one common latch strobe updates all outputs
			sclk_d = 1'b0;
			if (load_n) begin
				load_n_d = 1'b0;
			end else begin
				busy_d = 1'b0;
				done_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sr_q <= '0;
			bits_q <= '0;
			busy_q <= 1'b0;
			phase_q <= 1'b0;
			sclk <= 1'b0;
			sdo <= 1'b0;
			load_n <= 1'b1;
			done <= 1'b0;
		end else begin
			sr_q <= sr_d;
			bits_q <= bits_d;
			busy_q <= busy_d;
			phase_q <= phase_d;
			sclk <= sclk_d;
			sdo <= sdo_d;
			load_n <= load_n_d;
			done <= done_d;
		end
	end
endmodule

// ==== hdl/dac_playback_sequencer.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - register mode and memory playback mode
// - shift chips serially, latch all together
// - internal update clock no faster than 64 kHz
// - two data registers per channel
// - register launch shifts, latches, clears launch
// - register mode ignores the update clock
// - memory playback starts on soft/external trigger
// - each tick refreshes channels, advances address
// - half, full, count-complete raise interrupt
// - single run stops, clears launch
// - repeat zeroes address, replays, no count-complete flag
// - repeat cleared: stop at next count
// - size bit moves only flag points
// - lower/upper buffers, sixteen channel segments
// - flags when channel sixteen tops buffer
// - wide sample: low word then high bits
// - straight binary codes, midscale zero volts
// - soft trigger starts programmed playback
// - per-event interrupt enables gate the status
// - size bit halves the 32K or 64K flag limit
module dac_playback_sequencer import dac_seq_pkg::*; (
	input wire logic clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ext_trigger,
	input wire logic ext_clock,
	input wire logic ext_inhibit,
	output logic dac_sclk,
	output logic dac_sdo,
	output logic dac_load_n,
	output logic irq
);
	logic [15:0] mem [MEM_WORDS];

	state_t state_q, state_d;
	ctrl_t ctrl_q, ctrl_d;
	flags_t flags_q, flags_d;
	logic [CODE_W-1:0] chan_q [NCHAN];
	logic [CODE_W-1:0] chan_d [NCHAN];
	logic [15:0] ptr_q, ptr_d;
	logic [16:0] cnt_q, cnt_d;
	logic [15:0] count_q, count_d;
	logic [31:0] rate_q, rate_d;
	logic [31:0] div_q, div_d;
	logic [MEM_AW-1:0] maddr_q, maddr_d;
	logic [3:0] ch_q, ch_d;
	logic word_q, word_d;
	logic tick_pend_q, tick_pend_d;
	logic ext_clock_q;
	logic [31:0] rdata_d;
	logic ready_d, err_d, irq_d;
	logic access, wr, mapped, soft_trig, trig, tick, tick_int, inhibited;
	logic shift_start, shift_done;
	logic [31:0] period;
	logic [5:0] reg_idx;
	logic [11:0] chan_off;
	logic [MEM_AW-1:0] fetch_addr;
	logic [16:0] limit, ptr_next17, cnt_end;
	logic [15:0] ptr_inc;
	logic [CHAIN_W-1:0] frame;

	assign access = psel && penable && pready;
	assign wr = access && pwrite;
	assign chan_off = paddr - ADDR_CHAN_BASE;
	assign reg_idx = chan_off[7:2];
	assign soft_trig = wr && paddr == ADDR_CTRL && pwdata[B_SOFT_TRIG];
	assign trig = soft_trig || ext_trigger;
	assign inhibited = ctrl_q.et && ext_inhibit;
	// a programmed rate above the ceiling is stretched to it
	assign period = (rate_q < MIN_PERIOD_CYC) ? MIN_PERIOD_CYC : rate_q;
	assign tick_int = div_q >= period - 32'h0000_0001;
	assign tick = ctrl_q.xc ? (ext_clock && !ext_clock_q) : tick_int;
	// wide samples take two words: bits 0..15 then bits 16..17
	assign fetch_addr = ctrl_q.wide ? {ptr_q[14], ch_q, ptr_q[13:0], word_q} : {ptr_q[15], ch_q, ptr_q[14:0]};
	assign ptr_inc = ctrl_q.wide ? {1'b0, ptr_q[14:0] + 15'h0001} : ptr_q + 16'h0001;
	// the size bit only moves the flag points, never the count or address
	assign limit = ctrl_q.half_size_memory ? (ctrl_q.wide ? LIMIT_WIDE : LIMIT_NARROW) >> 1
		: (ctrl_q.wide ? LIMIT_WIDE : LIMIT_NARROW);
	assign ptr_next17 = {1'b0, ptr_q} + 17'h0_0001;
	assign cnt_end = (count_q == 16'h0000) ? 17'h1_0000 : {1'b0, count_q};

	// built from the next values: the word fetched in the cycle that starts the shift must be in the frame
	always_comb begin
		for (int i = 0; i < NCHAN; i++) begin
			frame[CHAIN_W-1-i*CODE_W -: CODE_W] = chan_d[NCHAN-1-i];
		end
	end

	always_comb begin
		mapped = 1'b1;
		rdata_d = '0;
		case (paddr)
			ADDR_CTRL: begin
				rdata_d[B_WIDE] = ctrl_q.wide;
				rdata_d[B_ARM] = ctrl_q.arm;
				rdata_d[B_MEM_MODE] = ctrl_q.memory_mode_enable;
				rdata_d[B_XC] = ctrl_q.xc;
				rdata_d[B_ET] = ctrl_q.et;
				rdata_d[B_END_IE] = ctrl_q.end_irq_enable;
				rdata_d[B_FULL_IE] = ctrl_q.full_irq_enable;
				rdata_d[B_HALF_IE] = ctrl_q.half_irq_enable;
				rdata_d[B_BUSY] = state_q == S_REG_SHIFT || state_q == S_FETCH || state_q == S_SHIFT;
				rdata_d[B_HALFSZ] = ctrl_q.half_size_memory;
				rdata_d[B_MH] = inhibited;
				rdata_d[B_CONT] = ctrl_q.cont;
				rdata_d[B_CC] = flags_q.cc;
				rdata_d[B_FULL] = flags_q.full;
				rdata_d[B_HALF] = flags_q.half;
			end
			ADDR_PTR: rdata_d[15:0] = ptr_q;
			ADDR_COUNT: rdata_d[15:0] = count_q;
			ADDR_RATE: rdata_d = rate_q;
			ADDR_MADDR: rdata_d[MEM_AW-1:0] = maddr_q;
			ADDR_MDATA: rdata_d[15:0] = mem[maddr_q];
			default: begin
				if (paddr >= ADDR_CHAN_BASE && paddr <= ADDR_CHAN_LAST && paddr[1:0] == 2'b00) begin
					if (reg_idx[0]) begin
						rdata_d[1:0] = chan_q[reg_idx[4:1]][17:16];
					end else begin
						rdata_d[15:0] = chan_q[reg_idx[4:1]][15:0];
					end
				end else begin
					mapped = 1'b0;
				end
			end
		endcase
	end

	// the answer is prepared in the setup cycle, so every access takes two cycles
	assign ready_d = psel && !penable;
	assign err_d = psel && !penable && !mapped;
	assign irq_d = (flags_q.cc && ctrl_q.end_irq_enable) || (flags_q.full && ctrl_q.full_irq_enable)
		|| (flags_q.half && ctrl_q.half_irq_enable);

	always_comb begin
		state_d = state_q;
		ctrl_d = ctrl_q;
		flags_d = flags_q;
		chan_d = chan_q;
		ptr_d = ptr_q;
		cnt_d = cnt_q;
		count_d = count_q;
		rate_d = rate_q;
		maddr_d = maddr_q;
		ch_d = ch_q;
		word_d = word_q;
		tick_pend_d = tick_pend_q;
		shift_start = 1'b0;
		div_d = (state_q == S_IDLE || tick_int) ? 32'h0000_0000 : div_q + 32'h0000_0001;

		if (wr && !pslverr) begin
			case (paddr)
				ADDR_CTRL: begin
					ctrl_d.wide = pwdata[B_WIDE];
					ctrl_d.arm = pwdata[B_ARM];
					ctrl_d.memory_mode_enable = pwdata[B_MEM_MODE];
					ctrl_d.xc = pwdata[B_XC];
					ctrl_d.et = pwdata[B_ET];
					ctrl_d.end_irq_enable = pwdata[B_END_IE];
					ctrl_d.full_irq_enable = pwdata[B_FULL_IE];
					ctrl_d.half_irq_enable = pwdata[B_HALF_IE];
					ctrl_d.half_size_memory = pwdata[B_HALFSZ];
					ctrl_d.cont = pwdata[B_CONT];
					// status bits clear on writing one; a same-cycle event below still wins
					flags_d.cc = flags_q.cc && !pwdata[B_CC];
					flags_d.full = flags_q.full && !pwdata[B_FULL];
					flags_d.half = flags_q.half && !pwdata[B_HALF];
				end
				ADDR_PTR: ptr_d = pwdata[15:0];
				ADDR_COUNT: count_d = pwdata[15:0];
				ADDR_RATE: rate_d = pwdata;
				ADDR_MADDR: maddr_d = pwdata[MEM_AW-1:0];
				ADDR_MDATA: maddr_d = maddr_q + 20'h0_0001;
				default: begin
					if (reg_idx[0]) begin
						chan_d[reg_idx[4:1]][17:16] = pwdata[1:0];
					end else begin
						chan_d[reg_idx[4:1]][15:0] = pwdata[15:0];
					end
				end
			endcase
		end else if (access && !pwrite && paddr == ADDR_MDATA) begin
			maddr_d = maddr_q + 20'h0_0001;
		end

		if (tick && state_q != S_WAIT && state_q != S_IDLE) begin
			tick_pend_d = 1'b1;
		end

		case (state_q)
			S_IDLE: begin
				tick_pend_d = 1'b0;
				if (ctrl_q.arm && !ctrl_q.memory_mode_enable) begin
					shift_start = 1'b1;
					state_d = S_REG_SHIFT;
				end else if (ctrl_q.arm && ctrl_q.memory_mode_enable && trig) begin
					cnt_d = '0;
					state_d = S_WAIT;
				end
			end
			S_REG_SHIFT: begin
				if (shift_done) begin
					ctrl_d.arm = 1'b0;
					state_d = S_IDLE;
				end
			end
			S_WAIT: begin
				if (!ctrl_q.arm) begin
					state_d = S_IDLE;
				end else if ((tick || tick_pend_q) && !inhibited) begin
					tick_pend_d = 1'b0;
					ch_d = '0;
					word_d = 1'b0;
					state_d = S_FETCH;
				end
			end
			S_FETCH: begin
				if (word_q) begin
					chan_d[ch_q][17:16] = mem[fetch_addr][1:0];
				end else begin
					chan_d[ch_q][15:0] = mem[fetch_addr];
				end
				if (ctrl_q.wide && !word_q) begin
					word_d = 1'b1;
				end else begin
					word_d = 1'b0;
					ch_d = ch_q + 4'h1;
					if (ch_q == 4'hF) begin
						if (ptr_next17 == (limit >> 1)) begin
							flags_d.half = 1'b1;
						end
						if (ptr_next17 == limit) begin
							flags_d.full = 1'b1;
						end
						shift_start = 1'b1;
						state_d = S_SHIFT;
					end
				end
			end
			S_SHIFT: begin
				if (shift_done) begin
					ptr_d = ptr_inc;
					cnt_d = cnt_q + 17'h0_0001;
					state_d = S_WAIT;
					if (cnt_q + 17'h0_0001 == cnt_end) begin
						if (ctrl_q.cont && ctrl_q.arm) begin
							ptr_d = '0;
							cnt_d = '0;
						end else begin
							ctrl_d.arm = 1'b0;
							flags_d.cc = 1'b1;
							state_d = S_IDLE;
						end
					end
				end
			end
			default: state_d = S_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (wr && paddr == ADDR_MDATA) begin
			mem[maddr_q] <= pwdata[15:0];
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= S_IDLE;
			ctrl_q <= RST_CTRL;
			flags_q <= '0;
			for (int i = 0; i < NCHAN; i++) begin
				chan_q[i] <= RST_CHAN_CODE;
			end
			ptr_q <= '0;
			cnt_q <= '0;
			count_q <= '0;
			rate_q <= RST_RATE_CYC;
			div_q <= '0;
			maddr_q <= '0;
			ch_q <= '0;
			word_q <= 1'b0;
			tick_pend_q <= 1'b0;
			ext_clock_q <= 1'b0;
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			irq <= 1'b0;
		end else begin
			state_q <= state_d;
			ctrl_q <= ctrl_d;
			flags_q <= flags_d;
			chan_q <= chan_d;
			ptr_q <= ptr_d;
			cnt_q <= cnt_d;
			count_q <= count_d;
			rate_q <= rate_d;
			div_q <= div_d;
			maddr_q <= maddr_d;
			ch_q <= ch_d;
			word_q <= word_d;
			tick_pend_q <= tick_pend_d;
			ext_clock_q <= ext_clock;
			prdata <= rdata_d;
			pready <= ready_d;
			pslverr <= err_d;
			irq <= irq_d;
		end
	end

	dac_chain_shifter u_shifter (
		.clk(clk),
		.nrst(nrst),
		.start(shift_start),
		.frame(frame),
		.sclk(dac_sclk),
		.sdo(dac_sdo),
		.load_n(dac_load_n),
		.done(shift_done)
	);
endmodule

// ==== hdl/dac_seq_pkg.sv ====
package dac_seq_pkg;
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned MAX_UPDATE_HZ = 64_000;
	// least spacing of two updates, rounded up to whole cycles
	localparam logic [31:0] MIN_PERIOD_CYC = 32'((CLK_HZ + MAX_UPDATE_HZ - 1) / MAX_UPDATE_HZ);
	localparam logic [31:0] RST_RATE_CYC = 32'h0000_9C40;
	localparam int NCHAN = 16;
	localparam int CODE_W = 18;
	localparam int CHAIN_W = NCHAN * CODE_W;
	localparam int MEM_AW = 20;
	localparam int MEM_WORDS = 1 << MEM_AW;
	localparam logic [CODE_W-1:0] RST_CHAN_CODE = 18'h2_0000;
	localparam logic [16:0] LIMIT_WIDE = 17'h0_8000;
	localparam logic [16:0] LIMIT_NARROW = 17'h1_0000;

	localparam logic [11:0] ADDR_CTRL = 12'h000;
	localparam logic [11:0] ADDR_PTR = 12'h004;
	localparam logic [11:0] ADDR_COUNT = 12'h008;
	localparam logic [11:0] ADDR_RATE = 12'h00C;
	localparam logic [11:0] ADDR_MADDR = 12'h010;
	localparam logic [11:0] ADDR_MDATA = 12'h014;
	localparam logic [11:0] ADDR_CHAN_BASE = 12'h040;
	localparam logic [11:0] ADDR_CHAN_LAST = 12'h0BC;

	localparam int B_WIDE = 16;
	localparam int B_ARM = 15;
	localparam int B_MEM_MODE = 14;
	localparam int B_SOFT_TRIG = 13;
	localparam int B_XC = 12;
	localparam int B_ET = 11;
	localparam int B_END_IE = 10;
	localparam int B_FULL_IE = 9;
	localparam int B_HALF_IE = 8;
	localparam int B_BUSY = 7;
	localparam int B_HALFSZ = 5;
	localparam int B_MH = 4;
	localparam int B_CONT = 3;
	localparam int B_CC = 2;
	localparam int B_FULL = 1;
	localparam int B_HALF = 0;

	typedef struct packed {
		logic wide;
		logic arm;
		logic memory_mode_enable;
		logic xc;
		logic et;
		logic end_irq_enable;
		logic full_irq_enable;
		logic half_irq_enable;
		logic half_size_memory;
		logic cont;
	} ctrl_t;

	typedef struct packed {
		logic cc;
		logic full;
		logic half;
	} flags_t;

	localparam ctrl_t RST_CTRL = '{wide: 1'b1, default: 1'b0};

	typedef enum logic [2:0] {S_IDLE, S_REG_SHIFT, S_WAIT, S_FETCH, S_SHIFT} state_t;
endpackage

// ==== tb/dac_chain_model.sv ====
`timescale 1ns/1ps
module dac_chain_model import dac_seq_pkg::*; (
	input wire logic clk,
	input wire logic nrst,
	input wire logic sclk,
	input wire logic sdo,
	input wire logic load_n,
	output logic [CHAIN_W-1:0] held,
	output logic [15:0] nbits,
	output logic fresh
);
	logic sclk_prev;
	logic [CHAIN_W-1:0] sr;
	logic [15:0] cnt;
	// chips sample on the rising serial clock; the first bit in ends at the far end of the chain
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sclk_prev <= 1'b0;
			sr <= '0;
			cnt <= 16'h0000;
			held <= '0;
			nbits <= 16'h0000;
			fresh <= 1'b0;
		end else begin
			sclk_prev <= sclk;
			fresh <= 1'b0;
			if (sclk && !sclk_prev) begin
				sr <= {sr[CHAIN_W-2:0], sdo};
				cnt <= cnt + 16'h0001;
			end
			if (!load_n) begin
				held <= sr;
				nbits <= cnt;
				cnt <= 16'h0000;
				fresh <= 1'b1;
			end
		end
	end
endmodule

// ==== tb/dac_seq_sva.sv ====
`timescale 1ns/1ps
module dac_seq_sva import dac_seq_pkg::*; (
	input wire logic clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic ext_trigger,
	input wire logic ext_clock,
	input wire logic ext_inhibit,
	input wire logic dac_sclk,
	input wire logic dac_sdo,
	input wire logic dac_load_n,
	input wire logic irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	logic sclk_prev_q;
	logic sclk_prev_d;
	logic [15:0] bits_q;
	logic [15:0] bits_d;
	always_comb begin
		sclk_prev_d = dac_sclk;
		bits_d = bits_q;
		if (!dac_load_n) begin
			bits_d = 16'h0000;
		end else if (dac_sclk && !sclk_prev_q) begin
			bits_d = bits_q + 16'h0001;
		end
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sclk_prev_q <= 1'b0;
			bits_q <= 16'h0000;
		end else begin
			sclk_prev_q <= sclk_prev_d;
			bits_q <= bits_d;
		end
	end
	sequence ctrl_write;
		psel && penable && pready && pwrite && paddr == ADDR_CTRL;
	endsequence
	sequence reg_launch;
		ctrl_write ##0 pwdata[B_ARM] && !pwdata[B_MEM_MODE];
	endsequence
	AST_SETUP_ANSWER: assert property (psel && !penable |=> pready) else $error("no ready after setup");
	AST_READY_PULSE: assert property (pready |=> !pready) else $error("ready longer than one cycle");
	AST_ERR_WITH_READY: assert property (pslverr |-> pready) else $error("error without ready");
	AST_LOAD_PULSE: assert property (!dac_load_n |=> dac_load_n) else $error("latch strobe too long");
	AST_SDO_STABLE: assert property (dac_sclk |-> $stable(dac_sdo)) else $error("data moved at clock high");
	AST_SCLK_CELL: assert property (dac_sclk |=> !dac_sclk) else $error("serial clock high too long");
	AST_LAUNCH_SHIFT: assert property (reg_launch |-> ##[1:8] dac_sclk) else $error("launch did not shift");
	AST_FRAME_BITS: assert property (!dac_load_n |-> bits_q == 16'(CHAIN_W)) else $error("frame length wrong");
	AST_IRQ_CLEAR: assert property (ctrl_write ##0 pwdata[10:8] == 3'b000 |-> ##[1:2] !irq)
		else $error("irq stayed with enables off");
endmodule
bind dac_playback_sequencer dac_seq_sva dac_seq_sva_inst (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.ext_trigger(ext_trigger), .ext_clock(ext_clock), .ext_inhibit(ext_inhibit), .dac_sclk(dac_sclk),
	.dac_sdo(dac_sdo), .dac_load_n(dac_load_n), .irq(irq));

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin bad_count++; \
	$display("unexpected at %0t got %h expected %h", $time, got, exp); end end
module testbench import dac_seq_pkg::*;;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic ext_trigger = 1'b0;
	logic ext_clock = 1'b0;
	logic ext_inhibit = 1'b0;
	logic [31:0] prdata;
	logic pready, pslverr, dac_sclk, dac_sdo, dac_load_n, irq, fresh;
	logic [CHAIN_W-1:0] held;
	logic [15:0] nbits;
	logic [32:0] exp_q[$];
	logic [32:0] e;
	logic [CODE_W-1:0] codes[NCHAN];
	int bad_count = 0;
	int samples_checked = 0;
	always #12.5 clk = ~clk;
	dac_playback_sequencer dac_playback_sequencer_inst (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_trigger(ext_trigger), .ext_clock(ext_clock), .ext_inhibit(ext_inhibit), .dac_sclk(dac_sclk),
		.dac_sdo(dac_sdo),
		.dac_load_n(dac_load_n), .irq(irq));
	dac_chain_model dac_chain_model_inst (.clk(clk), .nrst(nrst), .sclk(dac_sclk), .sdo(dac_sdo),
		.load_n(dac_load_n), .held(held), .nbits(nbits), .fresh(fresh));
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		// this wait ends on pready; the watchdog ends it if none comes
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [32:0] x);
		exp_q.push_back(x);
		apb(1'b0, a, 32'h0000_0000);
	endtask
	task automatic wait_load;
		while (fresh !== 1'b1) begin
			@(posedge clk);
		end
		repeat (4) @(posedge clk);
	endtask
	task conclude;
		$display("mismatches %0d comparisons %0d", bad_count, samples_checked);
		if (bad_count == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// results are paired with the oldest note in arrival order
	always @(posedge clk) begin
		if (psel && penable && pready && !pwrite) begin
			e = exp_q.pop_front();
			`CHK({pslverr, prdata}, e)
		end
		if (fresh) begin
			`CHK(nbits, 16'(CHAIN_W))
			for (int c = 0; c < NCHAN; c++) begin
				e = exp_q.pop_front();
				`CHK({15'h0, held[c*CODE_W +: CODE_W]}, e)
			end
		end
	end
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		conclude();
	end
	initial begin
		void'($urandom(32'h9c72_7804));
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		rd(ADDR_CTRL, 33'h0_0001_0000);
		rd(ADDR_CHAN_BASE + 12'h004, 33'h0_0000_0002);
		rd(12'h020, 33'h1_0000_0000);
		for (int c = 0; c < NCHAN; c++) begin
			codes[c] = 18'($urandom);
			apb(1'b1, ADDR_CHAN_BASE + 12'(8 * c), {16'h0000, codes[c][15:0]});
			apb(1'b1, ADDR_CHAN_BASE + 12'(8 * c + 4), {30'h0, codes[c][17:16]});
		end
		rd(ADDR_CHAN_BASE + 12'h028, {17'h0_0000, codes[5][15:0]});
		for (int c = 0; c < NCHAN; c++) exp_q.push_back({15'h0, codes[c]});
		apb(1'b1, ADDR_CTRL, 32'h0001_8000);
		wait_load();
		rd(ADDR_CTRL, 33'h0_0001_0000);
		apb(1'b1, ADDR_RATE, 32'h0000_0271);
		apb(1'b1, ADDR_COUNT, 32'h0000_0001);
		for (int c = 0; c < NCHAN; c++) begin
			codes[c] = 18'($urandom);
			apb(1'b1, ADDR_MADDR, {13'h0000, 4'(c), 15'h0000});
			apb(1'b1, ADDR_MDATA, {16'h0000, codes[c][15:0]});
			apb(1'b1, ADDR_MDATA, {30'h0, codes[c][17:16]});
			exp_q.push_back({15'h0, codes[c]});
		end
		apb(1'b1, ADDR_CTRL, 32'h0001_C400);
		apb(1'b1, ADDR_CTRL, 32'h0001_E400);
		wait_load();
		rd(ADDR_CTRL, 33'h0_0001_4404);
		`CHK(irq, 1'b1)
		rd(ADDR_PTR, 33'h0_0000_0001);
		apb(1'b1, ADDR_CTRL, 32'h0001_0007);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b0)
		// narrow run on the external trigger and clock; high bits stay from the wide run
		apb(1'b1, ADDR_PTR, 32'h0000_0000);
		ext_inhibit <= 1'b1;
		apb(1'b1, ADDR_CTRL, 32'h0000_D800);
		rd(ADDR_CTRL, 33'h0_0000_D810);
		ext_inhibit <= 1'b0;
		for (int c = 0; c < NCHAN; c++) exp_q.push_back({15'h0, codes[c]});
		ext_trigger <= 1'b1;
		@(posedge clk);
		ext_trigger <= 1'b0;
		ext_clock <= 1'b1;
		@(posedge clk);
		ext_clock <= 1'b0;
		wait_load();
		rd(ADDR_CTRL, 33'h0_0000_5804);
		conclude();
	end
endmodule
